// *** include/ir_uart_pkg.sv ***
// constants and types for the infrared serial port control registers
package ir_uart_pkg;
	// ------------------------------------------------------------
	// register indices and byte addresses (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [7:0] LINE_FORMAT_IDX = 8'h40;
	localparam logic [7:0] IRQ_ENABLE_IDX = 8'h41;
	localparam logic [7:0] NINTH_BIT_IDX = 8'h42;
	localparam logic [7:0] STATUS_IDX = 8'h43;
	localparam logic [7:0] DATA_IDX = 8'h47;
	localparam logic [11:0] LINE_FORMAT_ADDR = {2'h0, LINE_FORMAT_IDX, 2'h0};
	localparam logic [11:0] IRQ_ENABLE_ADDR = {2'h0, IRQ_ENABLE_IDX, 2'h0};
	localparam logic [11:0] NINTH_BIT_ADDR = {2'h0, NINTH_BIT_IDX, 2'h0};
	localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};
	localparam logic [11:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int LOOPBACK_BIT = 7;
	localparam int MODULE_ON_BIT = 6;
	localparam int NINE_SEL_BIT = 4;
	localparam int EXIT_SEL_BIT = 3;
	localparam int IDLE_START_BIT = 2;
	localparam int PARITY_ON_BIT = 1;
	localparam int PARITY_ODD_BIT = 0;
	localparam int TX_EMPTY_IE_BIT = 7;
	localparam int TX_DONE_IE_BIT = 6;
	localparam int RX_FULL_IE_BIT = 5;
	localparam int IDLE_IE_BIT = 4;
	localparam int TX_ON_BIT = 3;
	localparam int RX_ON_BIT = 2;
	localparam int STANDBY_BIT = 1;
	localparam int BREAK_BIT = 0;
	localparam int RX_NINTH_BIT = 7;
	localparam int TX_NINTH_BIT = 6;
	localparam int ST_TX_EMPTY_BIT = 7;
	localparam int ST_TX_DONE_BIT = 6;
	localparam int ST_RX_FULL_BIT = 5;
	localparam int ST_IDLE_BIT = 4;
	localparam int ST_FRAME_ERR_BIT = 1;
	localparam int ST_PARITY_ERR_BIT = 0;
	// ------------------------------------------------------------
	// reset values, frame and timing constants
	// ------------------------------------------------------------
	localparam logic [7:0] LINE_FORMAT_RESET = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
	localparam logic [3:0] FRAME_LEN_8 = 4'ha;
	localparam logic [3:0] FRAME_LEN_9 = 4'hb;
	localparam logic [3:0] DATA_LEN_8 = 4'h8;
	localparam logic [3:0] DATA_LEN_9 = 4'h9;
	localparam logic [3:0] GUARD_LEN = 4'h1;
	localparam int BIT_CYCLES_DEFAULT = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_SHIFT = 2'h1} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3} rx_state_t;
endpackage : ir_uart_pkg

// *** include/tx_link_if.sv ***
// link between the transmit controller and the bit shifter
`timescale 1ns/1ps
interface tx_link_if;
	logic start;
	logic [10:0] frame;
	logic [3:0] len;
	logic bit_tick;
	logic busy;
	logic ser_out;
	modport ctrl (output start, output frame, output len, output bit_tick,
		input busy, input ser_out);
	modport eng (input start, input frame, input len, input bit_tick,
		output busy, output ser_out);
endinterface : tx_link_if

// *** src/tx_shifter.sv ***
// transmit shift register, sends one frame lsb first at the bit rate
`timescale 1ns/1ps
module tx_shifter
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// controller side
	tx_link_if.eng link
);
	ir_uart_pkg::tx_state_t state;
	logic [10:0] shreg;
	logic [3:0] remain;
	logic hold;

	// load on start, shift one bit per tick; line rests high when idle
	// last bit is held while the next frame loads, so breaks have no high gap
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ir_uart_pkg::TX_IDLE;
			shreg <= 11'h7ff;
			remain <= 4'h0;
			hold <= 1'b0;
			link.ser_out <= 1'b1;
		end
		else
		begin
			unique case (state)
				ir_uart_pkg::TX_IDLE:
				begin
					hold <= 1'b0;
					if (link.start)
					begin
						state <= ir_uart_pkg::TX_SHIFT;
						shreg <= link.frame;
						remain <= link.len;
						link.ser_out <= link.frame[0];
					end
					else if (!hold)
						link.ser_out <= 1'b1;
				end
				ir_uart_pkg::TX_SHIFT:
				begin
					if (link.bit_tick)
					begin
						if (remain == 4'h1)
						begin
							state <= ir_uart_pkg::TX_IDLE;
							hold <= 1'b1;
						end
						else
						begin
							shreg <= {1'b1, shreg[10:1]};
							link.ser_out <= shreg[1];
						end
						remain <= remain - 4'h1;
					end
				end
				default:
				begin
					state <= ir_uart_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// busy covers the whole frame including the cycle of the last bit
	assign link.busy = (state != ir_uart_pkg::TX_IDLE);
endmodule : tx_shifter

// *** src/ir_uart_ctrl.sv ***
// control registers, transmitter sequencing and receiver of the serial port
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module ir_uart_ctrl
#(
	parameter int BIT_CYCLES = ir_uart_pkg::BIT_CYCLES_DEFAULT
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// serial pins
	output logic tx_pin_o,
	output logic tx_pin_oe,
	input wire logic rx_pin_i,
	// interrupt requests
	output logic tx_irq,
	output logic rx_irq
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	tx_link_if link ();
	logic [7:0] line_format_ctrl;
	logic [7:0] irq_and_enable_ctrl;
	logic rx_ninth_bit, tx_ninth_bit;
	logic tx_buffer_empty, tx_done, rx_buffer_full, idle_flag;
	logic parity_err, frame_err, idle_armed;
	logic [7:0] tx_data, data_buffer_reg;
	logic aw_full, w_full, ar_take, aw_take, w_take, do_write;
	logic [11:0] waddr_q;
	logic [7:0] wbyte_q;
	logic wlane_q;
	logic wr_line, wr_ctrl, wr_ninth, wr_data, rd_data;
	logic module_on, nine, tx_on, rx_on, rx_standby, break_send;
	logic tx_on_q, pend_preamble, guard_due, can_issue;
	logic [15:0] baud_cnt;
	logic [3:0] frame_len, data_len;
	ir_uart_pkg::rx_state_t rx_state;
	logic rx_in, rx_prev, rx_en, samp, samp_val;
	logic [15:0] rx_cnt;
	logic [3:0] rx_bitn, ones_cnt;
	logic [8:0] rx_shreg, rx_char;
	logic char_done, idle_event, count_ones, mark;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// word address of a bus byte address
	function automatic logic [11:0] word_of(input logic [11:0] a);
		word_of = {a[11:2], 2'h0};
	endfunction : word_of

	// parity bit over seven or eight data bits
	function automatic logic parity_of(input logic [7:0] d, input logic n9,
		input logic odd);
		parity_of = (n9 ? ^d : ^d[6:0]) ^ odd;
	endfunction : parity_of

	// frame image, lsb first: start, data or parity msb, stop
	function automatic logic [10:0] build_frame(input logic [7:0] d, input logic n9,
		input logic parity_on, input logic odd, input logic b8);
		logic p;
		p = parity_of(d, n9, odd);
		if (n9)
			build_frame = {1'b1, (parity_on ? p : b8), d, 1'b0};
		else
			build_frame = {2'h3, (parity_on ? p : d[7]), d[6:0], 1'b0};
	endfunction : build_frame

	assign module_on = line_format_ctrl[ir_uart_pkg::MODULE_ON_BIT];
	assign nine = line_format_ctrl[ir_uart_pkg::NINE_SEL_BIT];
	assign tx_on = irq_and_enable_ctrl[ir_uart_pkg::TX_ON_BIT];
	assign rx_on = irq_and_enable_ctrl[ir_uart_pkg::RX_ON_BIT];
	assign rx_standby = irq_and_enable_ctrl[ir_uart_pkg::STANDBY_BIT];
	assign break_send = irq_and_enable_ctrl[ir_uart_pkg::BREAK_BIT];
	// nine-bit select stretches every frame except the one-bit guard by one bit
	assign frame_len = nine ? ir_uart_pkg::FRAME_LEN_9 : ir_uart_pkg::FRAME_LEN_8;
	assign data_len = nine ? ir_uart_pkg::DATA_LEN_9 : ir_uart_pkg::DATA_LEN_8;

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	assign aw_take = awvalid & awready;
	assign w_take = wvalid & wready;
	assign ar_take = arvalid & arready;
	assign do_write = aw_full & w_full & ~bvalid;
	assign wr_line = do_write & wlane_q & (word_of(waddr_q) == ir_uart_pkg::LINE_FORMAT_ADDR);
	assign wr_ctrl = do_write & wlane_q & (word_of(waddr_q) == ir_uart_pkg::IRQ_ENABLE_ADDR);
	assign wr_ninth = do_write & wlane_q & (word_of(waddr_q) == ir_uart_pkg::NINTH_BIT_ADDR);
	assign wr_data = do_write & wlane_q & (word_of(waddr_q) == ir_uart_pkg::DATA_ADDR);
	assign rd_data = ar_take & (word_of(araddr) == ir_uart_pkg::DATA_ADDR);

	// write channels are held separately; the response waits for both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= ir_uart_pkg::RESP_OKAY;
			waddr_q <= 12'h000;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
		end
		else
		begin
			awready <= ~(aw_full | aw_take);
			wready <= ~(w_full | w_take);
			if (aw_take)
				waddr_q <= awaddr;
			if (w_take)
			begin
				wbyte_q <= wdata[7:0];
				wlane_q <= wstrb[0];
			end
			aw_full <= do_write ? 1'b0 : (aw_full | aw_take);
			w_full <= do_write ? 1'b0 : (w_full | w_take);
			if (do_write)
			begin
				bvalid <= 1'b1;
				bresp <= (wr_line | wr_ctrl | wr_ninth | wr_data) ||
					(word_of(waddr_q) == ir_uart_pkg::STATUS_ADDR) || !wlane_q ?
					ir_uart_pkg::RESP_OKAY : ir_uart_pkg::RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= ir_uart_pkg::RESP_OKAY;
		end
		else
		begin
			arready <= ~(ar_take | (rvalid & ~rready));
			if (ar_take)
			begin
				rvalid <= 1'b1;
				rresp <= ir_uart_pkg::RESP_OKAY;
				unique case (word_of(araddr))
					ir_uart_pkg::LINE_FORMAT_ADDR: rdata <= {24'h0, line_format_ctrl};
					ir_uart_pkg::IRQ_ENABLE_ADDR: rdata <= {24'h0, irq_and_enable_ctrl};
					ir_uart_pkg::NINTH_BIT_ADDR: rdata <= {24'h0, rx_ninth_bit, tx_ninth_bit, 6'h0};
					ir_uart_pkg::STATUS_ADDR: rdata <= {24'h0, tx_buffer_empty, tx_done,
						rx_buffer_full, idle_flag, 2'h0, frame_err, parity_err};
					ir_uart_pkg::DATA_ADDR: rdata <= {24'h0, data_buffer_reg};
					default:
					begin
						rdata <= 32'h0000_0000;
						rresp <= ir_uart_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	// line format; unused bit 5 reads zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			line_format_ctrl <= ir_uart_pkg::LINE_FORMAT_RESET;
		else if (wr_line)
			line_format_ctrl <= wbyte_q & 8'hdf;
	end

	// direction bits ignore writes while the module is off; a write wins over a wakeup
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_and_enable_ctrl <= ir_uart_pkg::IRQ_ENABLE_RESET;
		else if (wr_ctrl)
		begin
			irq_and_enable_ctrl[7:4] <= wbyte_q[7:4];
			irq_and_enable_ctrl[1:0] <= wbyte_q[1:0];
			if (module_on)
				irq_and_enable_ctrl[3:2] <= wbyte_q[3:2];
		end
		else if (idle_event && rx_standby && !line_format_ctrl[ir_uart_pkg::EXIT_SEL_BIT])
			irq_and_enable_ctrl[ir_uart_pkg::STANDBY_BIT] <= 1'b0;
		else if (char_done && rx_standby && mark && line_format_ctrl[ir_uart_pkg::EXIT_SEL_BIT])
			irq_and_enable_ctrl[ir_uart_pkg::STANDBY_BIT] <= 1'b0;
	end

	// ninth bits and transmit data buffer are not touched by reset
	always_ff @(posedge aclk)
	begin
		if (wr_ninth)
			tx_ninth_bit <= wbyte_q[ir_uart_pkg::TX_NINTH_BIT];
		if (wr_data)
			tx_data <= wbyte_q;
	end

	// ------------------------------------------------------------
	// baud divider and transmit sequencing
	// ------------------------------------------------------------
	// divider stops with the module so the bit rate restarts cleanly
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !module_on || baud_cnt == 16'(BIT_CYCLES - 1))
			baud_cnt <= 16'h0000;
		else
			baud_cnt <= baud_cnt + 16'h0001;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			link.bit_tick <= 1'b0;
		else
			link.bit_tick <= module_on && baud_cnt == 16'(BIT_CYCLES - 1);
	end

	// start is a flop, so one idle cycle is skipped before busy shows;
	// nothing issues in the cycle tx on rises, so the preamble is queued first
	assign can_issue = module_on & tx_on & tx_on_q & ~link.busy & ~link.start;

	// break beats preamble, then guard one, then data; tx off stops new frames only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_on_q <= 1'b0;
			pend_preamble <= 1'b0;
			guard_due <= 1'b0;
			link.start <= 1'b0;
			link.frame <= 11'h7ff;
			link.len <= ir_uart_pkg::FRAME_LEN_8;
		end
		else
		begin
			tx_on_q <= tx_on;
			link.start <= 1'b0;
			if (can_issue && break_send)
			begin
				link.start <= 1'b1;
				link.frame <= 11'h000;
				link.len <= frame_len;
				pend_preamble <= 1'b0;
				guard_due <= 1'b1;
			end
			else if (can_issue && (pend_preamble || guard_due))
			begin
				link.start <= 1'b1;
				link.frame <= 11'h7ff;
				link.len <= pend_preamble ? frame_len : ir_uart_pkg::GUARD_LEN;
				pend_preamble <= 1'b0;
				guard_due <= 1'b0;
			end
			else if (can_issue && !tx_buffer_empty)
			begin
				link.start <= 1'b1;
				link.frame <= build_frame(tx_data, nine,
					line_format_ctrl[ir_uart_pkg::PARITY_ON_BIT],
					line_format_ctrl[ir_uart_pkg::PARITY_ODD_BIT], tx_ninth_bit);
				link.len <= frame_len;
			end
			else if (tx_on && !tx_on_q && module_on)
				pend_preamble <= 1'b1;
		end
	end

	// empty set on hand-off wins over a data write in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !module_on)
			tx_buffer_empty <= 1'b1;
		else if (can_issue && !break_send && !pend_preamble && !guard_due && !tx_buffer_empty)
			tx_buffer_empty <= 1'b1;
		else if (wr_data)
			tx_buffer_empty <= 1'b0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !module_on)
			tx_done <= 1'b1;
		else
			tx_done <= tx_buffer_empty & ~wr_data & ~link.busy & ~link.start &
				~pend_preamble & ~guard_due & ~(break_send & tx_on);
	end

	// push-pull output enabled while the module is on and tx on, a frame is busy or the line is low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_pin_o <= 1'b1;
			tx_pin_oe <= 1'b0;
		end
		else
		begin
			tx_pin_o <= link.ser_out;
			tx_pin_oe <= module_on & (tx_on | link.busy | ~link.ser_out);
		end
	end

	tx_shifter u_tx_shifter
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.link(link)
	);

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	assign rx_en = module_on & rx_on;
	// loopback takes the raw shifter output, ahead of any line coding
	assign rx_in = line_format_ctrl[ir_uart_pkg::LOOPBACK_BIT] ? link.ser_out : rx_pin_i;
	assign samp = (rx_state == ir_uart_pkg::RX_IDLE) ? link.bit_tick : (rx_cnt == 16'h0000);
	assign samp_val = rx_in;
	assign char_done = (rx_state == ir_uart_pkg::RX_DATA) && samp && (rx_bitn == data_len);
	assign rx_char = nine ? rx_shreg : {1'b0, rx_shreg[8:1]};
	assign mark = nine ? rx_char[8] : rx_char[7];

	// start edge realigns the sample point to mid-bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !rx_en)
		begin
			rx_state <= ir_uart_pkg::RX_IDLE;
			rx_prev <= 1'b1;
			rx_cnt <= 16'h0000;
			rx_bitn <= 4'h0;
			rx_shreg <= 9'h000;
		end
		else
		begin
			rx_prev <= rx_in;
			rx_cnt <= (rx_cnt == 16'h0000) ? 16'(BIT_CYCLES - 1) : rx_cnt - 16'h0001;
			unique case (rx_state)
				ir_uart_pkg::RX_IDLE:
				begin
					if (rx_prev && !rx_in)
					begin
						rx_state <= ir_uart_pkg::RX_START;
						rx_cnt <= 16'(BIT_CYCLES / 2 - 1);
					end
				end
				ir_uart_pkg::RX_START:
				begin
					if (samp)
						rx_state <= samp_val ? ir_uart_pkg::RX_IDLE : ir_uart_pkg::RX_DATA;
					rx_bitn <= 4'h0;
				end
				ir_uart_pkg::RX_DATA:
				begin
					if (samp && rx_bitn != data_len)
					begin
						rx_shreg <= {samp_val, rx_shreg[8:1]};
						rx_bitn <= rx_bitn + 4'h1;
					end
					if (char_done)
						rx_state <= ir_uart_pkg::RX_IDLE;
				end
				default:
					rx_state <= ir_uart_pkg::RX_IDLE;
			endcase
		end
	end

	// ones counted in idle only, or also inside the frame after the start bit
	assign count_ones = (rx_state == ir_uart_pkg::RX_IDLE) ||
		(rx_state == ir_uart_pkg::RX_DATA && !line_format_ctrl[ir_uart_pkg::IDLE_START_BIT]);
	assign idle_event = rx_en && samp && samp_val && count_ones && ones_cnt == frame_len - 4'h1;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !rx_en || (samp && !samp_val))
			ones_cnt <= 4'h0;
		else if (samp && count_ones && ones_cnt != frame_len)
			ones_cnt <= ones_cnt + 4'h1;
	end

	// standby drops characters unless an address mark wakes the receiver
	always_ff @(posedge aclk)
	begin
		if (char_done && (!rx_standby || (mark && line_format_ctrl[ir_uart_pkg::EXIT_SEL_BIT])))
		begin
			data_buffer_reg <= rx_char[7:0];
			rx_ninth_bit <= mark;
		end
	end

	// receive flags: a hardware set wins over the clearing data read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_buffer_full <= 1'b0;
			idle_flag <= 1'b0;
			idle_armed <= 1'b0;
			parity_err <= 1'b0;
			frame_err <= 1'b0;
		end
		else if (char_done && (!rx_standby || (mark && line_format_ctrl[ir_uart_pkg::EXIT_SEL_BIT])))
		begin
			rx_buffer_full <= 1'b1;
			idle_armed <= 1'b1;
			parity_err <= line_format_ctrl[ir_uart_pkg::PARITY_ON_BIT] &&
				(mark != parity_of(rx_char[7:0], nine,
				line_format_ctrl[ir_uart_pkg::PARITY_ODD_BIT]));
			frame_err <= ~samp_val;
			if (rd_data)
				idle_flag <= 1'b0;
		end
		else if (idle_event && idle_armed && !rx_standby)
		begin
			idle_flag <= 1'b1;
			idle_armed <= 1'b0;
			if (rd_data)
			begin
				rx_buffer_full <= 1'b0;
				parity_err <= 1'b0;
				frame_err <= 1'b0;
			end
		end
		else if (rd_data)
		begin
			rx_buffer_full <= 1'b0;
			idle_flag <= 1'b0;
			parity_err <= 1'b0;
			frame_err <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// interrupt requests
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
		end
		else
		begin
			tx_irq <= module_on &
				((irq_and_enable_ctrl[ir_uart_pkg::TX_EMPTY_IE_BIT] & tx_buffer_empty) |
				(irq_and_enable_ctrl[ir_uart_pkg::TX_DONE_IE_BIT] & tx_done));
			rx_irq <= ~rx_standby &
				((irq_and_enable_ctrl[ir_uart_pkg::RX_FULL_IE_BIT] & rx_buffer_full) |
				(irq_and_enable_ctrl[ir_uart_pkg::IDLE_IE_BIT] & idle_flag));
		end
	end
endmodule : ir_uart_ctrl

// *** dv/ir_uart_ctrl_asserts.sv ***
// bus handshake and pin checks on the serial port control block
`timescale 1ns/1ps
module ir_uart_ctrl_asserts
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// pins and requests
	input wire logic tx_pin_o,
	input wire logic tx_pin_oe,
	input wire logic tx_irq,
	input wire logic rx_irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_reset_quiet: assert property ($rose(aresetn) |-> tx_pin_o && !tx_pin_oe && !tx_irq && !rx_irq)
		else $error("outputs not quiet after reset");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response not two cycles after take");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data not one cycle after take");
	a_b_once: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	a_r_once: assert property (rvalid && rready |=> !rvalid)
		else $error("read data repeated");
	a_aw_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	a_ar_blocked: assert property (rvalid |-> !arready && rdata[31:8] == 24'h0)
		else $error("read taken while data pending or upper bits set");
	a_ready_back: assert property ($fell(bvalid) |-> ##[0:2] (awready && wready))
		else $error("write ready not restored");
	a_pin_release: assert property ($fell(tx_pin_oe) |-> tx_pin_o)
		else $error("transmit pin released while low");
endmodule : ir_uart_ctrl_asserts
bind ir_uart_ctrl ir_uart_ctrl_asserts u_chk
(
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
	.rdata(rdata), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe),
	.tx_irq(tx_irq), .rx_irq(rx_irq)
);

// *** dv/serial_node.sv ***
// remote serial node that drives the receive pin
`timescale 1ns/1ps
module serial_node
#(
	parameter int BIT_NS = 400
)
(
	// line control
	input wire logic jam,
	output logic rx_line
);
	logic line = 1'b1;
	// pulled-up idle; jam holds the pin low to prove loopback ignores it
	assign rx_line = line & ~jam;
	// start, n bits lsb first, stop, then a short gap
	task automatic send(input logic [8:0] d, input int n);
		#10 line = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < n; i++)
		begin
			line = d[i];
			#(BIT_NS);
		end
		line = 1'b1;
		#(3 * BIT_NS);
	endtask : send
endmodule : serial_node

// *** dv/tb_ir_uart_control_regs.sv ***
// self-checking bench for the serial port control registers
`timescale 1ns/1ps
module tb_ir_uart_control_regs;
	typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] q;} row_t;
	localparam logic [11:0] LF = ir_uart_pkg::LINE_FORMAT_ADDR;
	localparam logic [11:0] IE = ir_uart_pkg::IRQ_ENABLE_ADDR;
	localparam logic [11:0] NB = ir_uart_pkg::NINTH_BIT_ADDR;
	localparam logic [11:0] ST = ir_uart_pkg::STATUS_ADDR;
	localparam logic [11:0] DT = ir_uart_pkg::DATA_ADDR;
	logic aclk, awready, wready, bvalid, arready, rvalid, tx_pin_o, tx_pin_oe, rx_pin_i;
	logic tx_irq, rx_irq;
	logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, jam = 1'b0;
	logic bready = 1'b1, rready = 1'b1;
	logic [3:0] wstrb = 4'h1;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [1:0] bresp, rresp;
	logic [1:0] er;
	int bad_count = 0;
	int comparisons = 0;
	int n;
	row_t rows [5];
	// eight cycles a bit keeps the mid-bit sample inside a shortened start bit
	ir_uart_ctrl #(.BIT_CYCLES(8)) u_dut
	(
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .rx_pin_i(rx_pin_i),
		.tx_irq(tx_irq), .rx_irq(rx_irq)
	);
	serial_node #(.BIT_NS(800)) u_node (.jam(jam), .rx_line(rx_pin_i));
	// 10 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic final_report();
		$display("mismatches %0d of %0d comparisons", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// a hung handshake ends the run
	task automatic tmo(input int lim);
		if (n < lim)
			return;
		bad_count++;
		$display("CHECK FAILED at %0t: wait limit reached", $time);
		final_report();
	endtask : tmo
	task automatic rst();
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask : rst
	// address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end
		while (bvalid !== 1'b1 && n < 40);
		tmo(40);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			n++;
		end
		while (rvalid !== 1'b1 && n < 40);
		q = rdata;
		tmo(40);
	endtask : rd
	// main sequence
	initial
	begin
		rows = '{'{LF, 8'hff, 8'hdf}, '{IE, 8'hfc, 8'hfc}, '{12'h000, 8'h11, 8'h00},
			'{IE, 8'h00, 8'h00}, '{LF, 8'h00, 8'h00}};
		rst();
		foreach (rows[i])
		begin
			er = (rows[i].a == 12'h000) ? ir_uart_pkg::RESP_SLVERR : ir_uart_pkg::RESP_OKAY;
			wr(rows[i].a, rows[i].d);
			chk({30'h0, bresp}, {30'h0, er});
			rd(rows[i].a);
			chk(q, {24'h0, rows[i].q});
			chk({30'h0, rresp}, {30'h0, er});
		end
		rst();
		rd(LF);
		chk(q, 32'h0);
		rd(IE);
		chk(q, 32'h0);
		rd(ST);
		chk(q, 32'hc0);
		wr(LF, 8'h40);
		wr(IE, 8'h80);
		rd(ST);
		chk({31'h0, tx_irq}, 32'h1);
		wr(DT, 8'h55);
		rd(ST);
		chk({31'h0, tx_irq}, 32'h0);
		wr(LF, 8'h00);
		rd(ST);
		chk(q & 32'hc0, 32'hc0);
		chk({31'h0, tx_irq}, 32'h0);
		// loopback with the pin jammed low; both directions on first
		rst();
		wr(LF, 8'hc0);
		wr(IE, 8'h2c);
		jam <= 1'b1;
		wr(DT, 8'ha5);
		for (n = 0; n < 400 && rx_irq !== 1'b1; n++) @(posedge aclk);
		tmo(400);
		chk({31'h0, rx_irq}, 32'h1);
		rd(DT);
		chk(q, 32'ha5);
		rd(NB);
		chk(q & 32'h80, 32'h80);
		jam <= 1'b0;
		wr(IE, 8'h04);
		// parity sense changed only between characters
		for (int p = 0; p < 4; p++)
		begin
			wr(LF, 8'h52 | 8'(p & 1));
			u_node.send({^8'h3c ^ p[0] ^ p[1], 8'h3c}, 9);
			rd(ST);
			chk(q & 32'h1, 32'(p[1]));
			rd(DT);
			chk(q, 32'h3c);
		end
		wr(IE, 8'h09);
		n = 0;
		repeat (200)
		begin
			@(posedge aclk);
			n += (tx_pin_o === 1'b0);
		end
		chk(32'(n >= 195), 32'h1);
		chk({31'h0, tx_pin_oe}, 32'h1);
		wr(IE, 8'h08);
		for (n = 0; n < 200 && tx_pin_o !== 1'b1; n++) @(posedge aclk);
		tmo(200);
		chk({31'h0, tx_pin_o}, 32'h1);
		wr(LF, 8'h48);
		wr(IE, 8'h26);
		u_node.send(9'h012, 8);
		chk({31'h0, rx_irq}, 32'h0);
		u_node.send(9'h092, 8);
		rd(IE);
		chk(q, 32'h24);
		chk({31'h0, rx_irq}, 32'h1);
		chk({31'h0, tx_pin_oe}, 32'h0);
		final_report();
	end
endmodule : tb_ir_uart_control_regs
